// [rtl/rss_pkg.sv]
package rss_pkg;

	// ------------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------------
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 8;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_SMI_ENABLE_GROUP5   = 8'h1A;
	localparam logic [ADDR_W-1:0] OFF_RSVD_1B   = 8'h1B;
	localparam logic [ADDR_W-1:0] OFF_EDGE_STS  = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_RSVD_1D   = 8'h1D;
	localparam logic [ADDR_W-1:0] OFF_FORCE_CHG = 8'h1E;
	localparam logic [ADDR_W-1:0] OFF_RATE_SHD  = 8'h1F;
	localparam logic [ADDR_W-1:0] OFF_SER1_SHD  = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_SER2_SHD  = 8'h21;

	// ------------------------------------------------------------------
	// Reset values and implemented-bit masks
	// ------------------------------------------------------------------
	localparam logic [DATA_W-1:0] RST_SMI_ENABLE_GROUP5   = 8'h00;
	localparam logic [DATA_W-1:0] RST_EDGE_STS  = 8'h00;
	localparam logic [DATA_W-1:0] RST_FORCE_CHG = 8'h01;
	localparam logic [DATA_W-1:0] RD_ZERO       = 8'h00;
	localparam logic [DATA_W-1:0] MASK_SMI_ENABLE_GROUP5  = 8'hCF;
	localparam logic [DATA_W-1:0] MASK_EDGE_STS = 8'h3F;
	localparam logic [DATA_W-1:0] MASK_FORCE    = 8'h03;
	localparam logic [DATA_W-1:0] MASK_RATE     = 8'hDF;
	localparam logic [DATA_W-1:0] MASK_FCR      = 8'hCF;

	// ------------------------------------------------------------------
	// Field widths and positions
	// ------------------------------------------------------------------
	localparam int unsigned EDGE_W     = 6;
	localparam int unsigned FORCE_W    = 2;
	localparam int unsigned PIN_W      = 7;
	localparam int unsigned MEDIA_IDX  = 6;
	localparam int unsigned DRV0_IDX   = 0;
	localparam int unsigned DRV1_IDX   = 1;
	localparam int unsigned PRIME_W    = 3;

endpackage

// [rtl/rss_edge_if.sv]
`timescale 1ns/10ps
interface rss_edge_if #(
	parameter int unsigned WIDTH = 7
);
	logic [WIDTH-1:0] level;
	logic [WIDTH-1:0] edge_pulse;

	modport src (output level, output edge_pulse);
	modport dst (input level, input edge_pulse);
endinterface

// [rtl/rss_edge_sync.sv]
`timescale 1ns/10ps
module rss_edge_sync
	import rss_pkg::*;
#(
	parameter int unsigned WIDTH = PIN_W
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	// Raw pins
	input  wire logic [WIDTH-1:0] i_pins,
	// Synchronised levels and edges
	rss_edge_if.src         edge_o
);

	logic [WIDTH-1:0]   meta_reg;
	logic [WIDTH-1:0]   sync_reg;
	logic [WIDTH-1:0]   prev_reg;
	logic [PRIME_W-1:0] prime_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= i_pins;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// Edges are held off until the chain holds real pin values, so a pin
	// that sits high through reset does not report a false edge.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prime_reg <= '0;
		end else begin
			prime_reg <= {prime_reg[PRIME_W-2:0], 1'b1};
		end
	end

	assign edge_o.level      = sync_reg;
	assign edge_o.edge_pulse = (sync_reg ^ prev_reg) & {WIDTH{prime_reg[PRIME_W-1]}};

endmodule // rss_edge_sync

// [rtl/rss_runtime_regs.sv]
`timescale 1ns/10ps
// Function
// - Enable bits gate sources onto group SMI
// - Offsets 1B and 1D read zero
// - Status bits 5:0 clear on write one
// - Either pin edge sets its status bit
// - Status bits 7:6 always read zero
// - Force bits: bit0 drive0, bit1 drive1
// - Software sets force bits, never clears
// - Step with drive0 select clears force0
// - Step with drive1 select clears force1
// - Media flag ORs forced terms and pin
// - Offset 1F mirrors floppy rate register
// - Offset 20 mirrors serial1 queue control
// - Offset 21 mirrors serial2 queue control
// - Pin driven only when route enabled
module rss_runtime_regs
	import rss_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	// Register port
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wr_data,
	input  wire logic              i_wr_en,
	input  wire logic              i_rd_en,
	output logic      [DATA_W-1:0] o_rd_data,
	// Group SMI
	input  wire logic [DATA_W-1:0] i_smi5_src,
	input  wire logic              i_smi_pin_route_enable,
	output logic                   o_group_mgmt_interrupt_n,
	output logic                   o_smi_pin_o,
	output logic                   o_smi_pin_oe,
	// Edge inputs
	input  wire logic [EDGE_W-1:0] i_general_io_edge,
	output logic      [EDGE_W-1:0] o_edge_status,
	// Floppy drive signals
	input  wire logic              i_head_step_n,
	input  wire logic              i_drive0_select_n,
	input  wire logic              i_drive1_select_n,
	input  wire logic              i_media_changed_in_n,
	output logic                   o_media_changed_flag,
	output logic      [FORCE_W-1:0] o_forced_media_change,
	// Shadowed core registers
	input  wire logic [DATA_W-1:0] i_floppy_rate,
	input  wire logic [DATA_W-1:0] i_serial1_queue_ctrl,
	input  wire logic [DATA_W-1:0] i_serial2_queue_ctrl
);

	// ------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------
	rss_edge_if #(.WIDTH(PIN_W)) pin_if ();

	logic [PIN_W-1:0] raw_pins;

	assign raw_pins = {i_media_changed_in_n, i_general_io_edge};

	rss_edge_sync #(
		.WIDTH (PIN_W)
	) u_sync (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_pins   (raw_pins),
		.edge_o   (pin_if)
	);

	logic [EDGE_W-1:0] edge_hit;
	logic              media_in_n;

	assign edge_hit   = pin_if.edge_pulse[EDGE_W-1:0];
	assign media_in_n = pin_if.level[MEDIA_IDX];

	// ------------------------------------------------------------------
	// Media input settling
	// ------------------------------------------------------------------
	logic [PRIME_W-2:0] media_ready_reg;
	logic               media_active;

	// The synchroniser clears to zero, which on this active-low pin would
	// read as a changed disk until real pin values have shifted through.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			media_ready_reg <= '0;
		end else begin
			media_ready_reg <= {media_ready_reg[PRIME_W-3:0], 1'b1};
		end
	end

	assign media_active = media_ready_reg[PRIME_W-2] && !media_in_n;

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------
	logic wr_en5;
	logic wr_sts;
	logic wr_force;

	assign wr_en5   = i_wr_en && (i_addr == OFF_SMI_ENABLE_GROUP5);
	assign wr_sts   = i_wr_en && (i_addr == OFF_EDGE_STS);
	assign wr_force = i_wr_en && (i_addr == OFF_FORCE_CHG);

	// ------------------------------------------------------------------
	// SMI enable group 5
	// ------------------------------------------------------------------
	logic [DATA_W-1:0] smi_enable_group5_reg;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			smi_enable_group5_reg <= RST_SMI_ENABLE_GROUP5;
		end else if (wr_en5) begin
			smi_enable_group5_reg <= i_wr_data & MASK_SMI_ENABLE_GROUP5;
		end
	end

	// ------------------------------------------------------------------
	// Group SMI output and pin
	// ------------------------------------------------------------------
	logic group_active;

	assign group_active = |(i_smi5_src & smi_enable_group5_reg);

	// The pin is open drain: it only ever pulls low, so its data is fixed.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_group_mgmt_interrupt_n <= 1'b1;
			o_smi_pin_o              <= 1'b0;
			o_smi_pin_oe             <= 1'b0;
		end else begin
			o_group_mgmt_interrupt_n <= !group_active;
			o_smi_pin_o              <= 1'b0;
			o_smi_pin_oe             <= group_active && i_smi_pin_route_enable;
		end
	end

	// ------------------------------------------------------------------
	// Edge interrupt status
	// ------------------------------------------------------------------
	logic [EDGE_W-1:0] edge_interrupt_status_reg;
	logic [EDGE_W-1:0] sts_clear;

	assign sts_clear = wr_sts ? i_wr_data[EDGE_W-1:0] : '0;

	// An edge arriving in the clearing cycle is kept, so no event is lost.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			edge_interrupt_status_reg <= RST_EDGE_STS[EDGE_W-1:0];
		end else begin
			edge_interrupt_status_reg <= (edge_interrupt_status_reg & ~sts_clear) | edge_hit;
		end
	end

	assign o_edge_status = edge_interrupt_status_reg;

	// ------------------------------------------------------------------
	// Forced media change
	// ------------------------------------------------------------------
	logic [FORCE_W-1:0] forced_media_change_reg;
	logic [FORCE_W-1:0] force_set;
	logic [FORCE_W-1:0] force_clr;

	assign force_set = wr_force ? i_wr_data[FORCE_W-1:0] : '0;
	assign force_clr[DRV0_IDX] = !i_head_step_n && !i_drive0_select_n;
	assign force_clr[DRV1_IDX] = !i_head_step_n && !i_drive1_select_n;

	// A software set in the same cycle as a step wins, so the request for a
	// forced change is not silently dropped.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			forced_media_change_reg <= RST_FORCE_CHG[FORCE_W-1:0];
		end else begin
			forced_media_change_reg <= (forced_media_change_reg & ~force_clr) | force_set;
		end
	end

	assign o_forced_media_change = forced_media_change_reg;

	// ------------------------------------------------------------------
	// Media changed flag for the floppy input register
	// ------------------------------------------------------------------
	logic media_flag;

	assign media_flag = (!i_drive0_select_n && forced_media_change_reg[DRV0_IDX])
		|| (!i_drive1_select_n && forced_media_change_reg[DRV1_IDX])
		|| media_active;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_media_changed_flag <= 1'b0;
		end else begin
			o_media_changed_flag <= media_flag;
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	logic [DATA_W-1:0] rd_mux;

	always_comb begin
		rd_mux = RD_ZERO;
		unique case (i_addr)
			OFF_SMI_ENABLE_GROUP5:   rd_mux = smi_enable_group5_reg;
			OFF_EDGE_STS:  rd_mux = {{(DATA_W-EDGE_W){1'b0}}, edge_interrupt_status_reg};
			OFF_FORCE_CHG: rd_mux = {{(DATA_W-FORCE_W){1'b0}}, forced_media_change_reg};
			OFF_RATE_SHD:  rd_mux = i_floppy_rate & MASK_RATE;
			OFF_SER1_SHD:  rd_mux = i_serial1_queue_ctrl & MASK_FCR;
			OFF_SER2_SHD:  rd_mux = i_serial2_queue_ctrl & MASK_FCR;
			default:       rd_mux = RD_ZERO;
		endcase
	end

	// Read data stand for one cycle only and return to zero otherwise.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rd_data <= RD_ZERO;
		end else if (i_rd_en) begin
			o_rd_data <= rd_mux;
		end else begin
			o_rd_data <= RD_ZERO;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	en5_reserved_a: assert property (
		(smi_enable_group5_reg & ~MASK_SMI_ENABLE_GROUP5) == RD_ZERO
	) else $error("reserved enable bits became set");

	group_smi_a: assert property (
		group_active |=> !o_group_mgmt_interrupt_n
	) else $error("enabled source did not assert group SMI");

	group_idle_a: assert property (
		!group_active |=> o_group_mgmt_interrupt_n
	) else $error("group SMI asserted with no enabled source");

	rsvd_read_a: assert property (
		i_rd_en && (i_addr == OFF_RSVD_1B || i_addr == OFF_RSVD_1D) |=> o_rd_data == RD_ZERO
	) else $error("reserved offset read nonzero");

	w1c_clear_a: assert property (
		wr_sts && !(|edge_hit)
		|=> (edge_interrupt_status_reg & $past(i_wr_data[EDGE_W-1:0])) == '0
	) else $error("write one did not clear status");

	w0_keep_a: assert property (
		wr_sts |=> (edge_interrupt_status_reg & ~$past(i_wr_data[EDGE_W-1:0]))
			== (($past(edge_interrupt_status_reg) & ~$past(i_wr_data[EDGE_W-1:0]))
			| ($past(edge_hit) & ~$past(i_wr_data[EDGE_W-1:0])))
	) else $error("write zero disturbed status");

	pin_edge_a: assert property (
		$changed(pin_if.level[0]) && $past(pin_if.level[0], 2) == $past(pin_if.level[0])
		&& $past(i_arst_n, 3) |=> edge_interrupt_status_reg[0]
	) else $error("pin edge did not set status");

	set_wins_a: assert property (
		|edge_hit |=> (edge_interrupt_status_reg & $past(edge_hit)) == $past(edge_hit)
	) else $error("edge lost against clear");

	sts_upper_a: assert property (
		i_rd_en && i_addr == OFF_EDGE_STS |=> o_rd_data[DATA_W-1:EDGE_W] == '0
	) else $error("status upper bits read nonzero");

	force_rsvd_a: assert property (
		i_rd_en && i_addr == OFF_FORCE_CHG
		|=> o_rd_data == {{(DATA_W-FORCE_W){1'b0}}, $past(forced_media_change_reg)}
	) else $error("force register read wrong");

	force_keep_a: assert property (
		wr_force && i_head_step_n
		|=> forced_media_change_reg == ($past(forced_media_change_reg)
			| $past(i_wr_data[FORCE_W-1:0]))
	) else $error("software write changed force bits wrongly");

	force_clr0_a: assert property (
		force_clr[DRV0_IDX] && !force_set[DRV0_IDX] |=> !forced_media_change_reg[DRV0_IDX]
	) else $error("step with drive0 did not clear force0");

	force_clr1_a: assert property (
		force_clr[DRV1_IDX] && !force_set[DRV1_IDX] |=> !forced_media_change_reg[DRV1_IDX]
	) else $error("step with drive1 did not clear force1");

	media_flag_a: assert property (
		##1 o_media_changed_flag == $past(media_flag)
	) else $error("media flag mismatch");

	rate_shadow_a: assert property (
		i_rd_en && i_addr == OFF_RATE_SHD |=> o_rd_data == ($past(i_floppy_rate) & MASK_RATE)
	) else $error("rate shadow wrong");

	ser1_shadow_a: assert property (
		i_rd_en && i_addr == OFF_SER1_SHD
		|=> o_rd_data == ($past(i_serial1_queue_ctrl) & MASK_FCR)
	) else $error("serial1 shadow wrong");

	ser2_shadow_a: assert property (
		i_rd_en && i_addr == OFF_SER2_SHD
		|=> o_rd_data == ($past(i_serial2_queue_ctrl) & MASK_FCR)
	) else $error("serial2 shadow wrong");

	pin_route_a: assert property (
		o_smi_pin_oe |-> $past(i_smi_pin_route_enable) && !o_group_mgmt_interrupt_n
	) else $error("pin driven without route enable");

	en5_write_a: assert property (
		wr_en5 |=> smi_enable_group5_reg == ($past(i_wr_data) & MASK_SMI_ENABLE_GROUP5)
	) else $error("enable write not stored with reserved bits cleared");

	en5_read_a: assert property (
		i_rd_en && i_addr == OFF_SMI_ENABLE_GROUP5 |=> o_rd_data == $past(smi_enable_group5_reg)
	) else $error("enable register read wrong");

	unmapped_read_a: assert property (
		i_rd_en && (i_addr < OFF_SMI_ENABLE_GROUP5 || i_addr > OFF_SER2_SHD)
		|=> o_rd_data == RD_ZERO
	) else $error("unmapped offset read nonzero");

	sts_read_a: assert property (
		i_rd_en && i_addr == OFF_EDGE_STS
		|=> o_rd_data[EDGE_W-1:0] == $past(edge_interrupt_status_reg)
	) else $error("status register read wrong");

	sts_hold_a: assert property (
		!wr_sts && !(|edge_hit) |=> $stable(edge_interrupt_status_reg)
	) else $error("status changed with no edge or write");

	force_hold_a: assert property (
		!wr_force && !(|force_clr) |=> $stable(forced_media_change_reg)
	) else $error("force bits changed with no write or step");

	route_off_a: assert property (
		!i_smi_pin_route_enable |=> !o_smi_pin_oe
	) else $error("pin driven while routing is off");

	cov_smi_pin: cover property (group_active && i_smi_pin_route_enable ##1 o_smi_pin_oe);
	cov_clear_race: cover property (wr_sts && |(sts_clear & edge_hit));
	cov_force_step: cover property (forced_media_change_reg[DRV0_IDX] && force_clr[DRV0_IDX]);
	cov_media_flag: cover property (!o_media_changed_flag ##1 o_media_changed_flag);

endmodule // rss_runtime_regs

// [tb/rss_host_model.sv]
`timescale 1ns/10ps
module rss_host_model
	import rss_pkg::*;
(
	// Clock and read return
	input  wire logic              i_clk,
	input  wire logic [DATA_W-1:0] i_rd_data,
	// Register port drive
	output logic      [ADDR_W-1:0] o_addr,
	output logic      [DATA_W-1:0] o_wr_data,
	output logic                   o_wr_en,
	output logic                   o_rd_en
);
	// ------------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------------
	// Each cycle leaves one idle edge after it, so a strobe never rises again in the
	// time step where it fell.
	initial begin
		o_addr = '0;
		o_wr_data = '0;
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
	end

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wr_data <= d;
		o_wr_en <= 1'b1;
		@(posedge i_clk);
		o_wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd_en <= 1'b1;
		@(posedge i_clk);
		o_rd_en <= 1'b0;
		#1 d = i_rd_data;
	endtask
endmodule // rss_host_model

// [tb/runtime_smi_status_shadow_regs_bench.sv]
`timescale 1ns/10ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module runtime_smi_status_shadow_regs_bench
	import rss_pkg::*;
;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic              i_clk = 1'b0;
	logic              i_arst_n = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, src, rate, s1, s2, d, w;
	logic              wen, ren, route, step_n, ds0_n, ds1_n, media_n;
	logic [EDGE_W-1:0] gpio, sts_out;
	logic              grp_n, pin_o, pin_oe, flag;
	logic [FORCE_W-1:0] frc_out;
	int                n_mismatch = 0;
	int                cmp_count = 0;
	int                cycles = 0;
	int                en5, sts, frc;

	always #2 i_clk = ~i_clk;

	rss_runtime_regs u_rss_runtime_regs (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(addr),
		.i_wr_data(wdata), .i_wr_en(wen), .i_rd_en(ren), .o_rd_data(rdata),
		.i_smi5_src(src), .i_smi_pin_route_enable(route), .o_group_mgmt_interrupt_n(grp_n),
		.o_smi_pin_o(pin_o), .o_smi_pin_oe(pin_oe), .i_general_io_edge(gpio),
		.o_edge_status(sts_out), .i_head_step_n(step_n), .i_drive0_select_n(ds0_n),
		.i_drive1_select_n(ds1_n), .i_media_changed_in_n(media_n),
		.o_media_changed_flag(flag), .o_forced_media_change(frc_out),
		.i_floppy_rate(rate), .i_serial1_queue_ctrl(s1), .i_serial2_queue_ctrl(s2));

	rss_host_model u_rss_host_model (.i_clk(i_clk), .i_rd_data(rdata), .o_addr(addr),
		.o_wr_data(wdata), .o_wr_en(wen), .o_rd_en(ren));

	// ------------------------------------------------------------------
	// Verdict and hang guard
	// ------------------------------------------------------------------
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic chk_rd(input logic [ADDR_W-1:0] a, input int exp);
		u_rss_host_model.rd(a, d);
		`CHK(d, exp[7:0])
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{src, route, gpio, rate, s1, s2} = '0;
		{step_n, ds0_n, ds1_n, media_n} = 4'hF;
		void'($urandom(6958));
		repeat (16) @(posedge i_clk);
		i_arst_n <= 1'b1;
		en5 = 0;
		sts = 0;
		frc = 1;
		chk_rd(OFF_SMI_ENABLE_GROUP5, en5);
		chk_rd(OFF_EDGE_STS, sts);
		chk_rd(OFF_FORCE_CHG, frc);
		// Writable bits, reserved places and an unmapped address.
		en5 = $urandom & 8'hCF;
		u_rss_host_model.wr(OFF_SMI_ENABLE_GROUP5, en5[7:0] | 8'h30);
		u_rss_host_model.wr(OFF_RSVD_1B, 8'hFF);
		u_rss_host_model.wr(OFF_RSVD_1D, 8'hFF);
		chk_rd(OFF_SMI_ENABLE_GROUP5, en5);
		chk_rd(OFF_RSVD_1B, 0);
		chk_rd(OFF_RSVD_1D, 0);
		chk_rd(8'h40, 0);
		// Group interrupt and its routing onto the pin.
		for (int k = 0; k < 6; k++) begin
			en5 = (k == 0) ? 8'hFF : $urandom;
			u_rss_host_model.wr(OFF_SMI_ENABLE_GROUP5, en5[7:0]);
			@(posedge i_clk);
			src <= (k == 1) ? 8'h30 : $urandom;
			route <= k[0];
			repeat (3) @(posedge i_clk);
			`CHK(grp_n, !(|(src & en5[7:0] & 8'hCF)))
			`CHK(pin_oe, (|(src & en5[7:0] & 8'hCF)) && route)
			`CHK(pin_o, 1'b0)
		end
		// Edge status: rising then falling edges, then partial clears.
		for (int k = 0; k < 4; k++) begin
			w = $urandom;
			@(posedge i_clk);
			gpio <= gpio ^ w[5:0];
			sts = sts | w[5:0];
			repeat (6) @(posedge i_clk);
			`CHK(sts_out, sts[5:0])
			chk_rd(OFF_EDGE_STS, sts);
			w = $urandom;
			u_rss_host_model.wr(OFF_EDGE_STS, w);
			sts = sts & ~w & 8'h3F;
			chk_rd(OFF_EDGE_STS, sts);
		end
		// An edge landing in the clearing cycle survives the clear.
		w = $urandom | 8'h01;
		@(posedge i_clk);
		gpio <= gpio ^ w[5:0];
		@(posedge i_clk);
		u_rss_host_model.wr(OFF_EDGE_STS, 8'hFF);
		sts = w[5:0];
		chk_rd(OFF_EDGE_STS, sts);
		// Force bits are set by software only and cleared by stepping.
		u_rss_host_model.wr(OFF_FORCE_CHG, 8'h02);
		frc = 3;
		u_rss_host_model.wr(OFF_FORCE_CHG, 8'h00);
		chk_rd(OFF_FORCE_CHG, frc);
		for (int k = 0; k < 8; k++) begin
			@(posedge i_clk);
			{ds0_n, ds1_n, media_n} <= k[2:0];
			repeat (4) @(posedge i_clk);
			`CHK(flag, (!ds0_n && frc[0]) || (!ds1_n && frc[1]) || !media_n)
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge i_clk);
			{step_n, ds0_n, ds1_n, media_n} <= (k == 0) ? 4'b0011 : 4'b0101;
			@(posedge i_clk);
			step_n <= 1'b1;
			frc = frc & ~(1 << k);
			repeat (2) @(posedge i_clk);
			`CHK(frc_out, frc[1:0])
			chk_rd(OFF_FORCE_CHG, frc);
		end
		repeat (4) @(posedge i_clk);
		`CHK(flag, 1'b0)
		// Read-only mirrors with reserved bits masked.
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk);
			rate <= $urandom;
			s1 <= $urandom;
			s2 <= $urandom;
			@(posedge i_clk);
			u_rss_host_model.wr(OFF_RATE_SHD, 8'hFF);
			chk_rd(OFF_RATE_SHD, rate & 8'hDF);
			chk_rd(OFF_SER1_SHD, s1 & 8'hCF);
			chk_rd(OFF_SER2_SHD, s2 & 8'hCF);
		end
		close_out();
	end
endmodule // runtime_smi_status_shadow_regs_bench
